//--- hw/card_host_pkg.sv
// Package: constants, register map and carrier structs of the card host strobe block
package card_host_pkg;

  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned INIT_TIME_US     = 10;
  localparam int unsigned INIT_CYCLES      = INIT_TIME_US * CLK_MHZ;
  localparam int unsigned PULSE_TIME_NS    = 100;
  localparam int unsigned PULSE_CYCLES     = (PULSE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W            = 16;

  localparam logic [7:0]  ADDR_CTRL        = 8'h00;
  localparam logic [7:0]  ADDR_STATUS      = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h0C;
  localparam logic [7:0]  ADDR_READ_DATA   = 8'h10;
  localparam logic [7:0]  ADDR_CFG_DATA    = 8'h14;

  localparam int unsigned CTRL_BUSY        = 0;
  localparam int unsigned CTRL_IO_MODE     = 1;
  localparam int unsigned CTRL_LEVEL_IRQ   = 2;
  localparam int unsigned CTRL_CARD_IRQ    = 3;
  localparam int unsigned CTRL_DMA_REQ     = 4;
  localparam int unsigned CTRL_SOFT_RESET  = 5;
  localparam int unsigned CTRL_W           = 6;

  localparam int unsigned ST_READY         = 0;
  localparam int unsigned ST_DISK_MODE     = 1;
  localparam int unsigned ST_DMA_ACTIVE    = 2;
  localparam int unsigned ST_IRQ_PENDING   = 3;
  localparam int unsigned ST_INIT_DONE     = 4;

  localparam int unsigned EV_READ_STROBE   = 0;
  localparam int unsigned EV_DMA_ACK       = 1;
  localparam int unsigned EV_INIT_DONE     = 2;
  localparam int unsigned EV_W             = 3;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [2:0] {
    INIT_S  = 3'b001,
    READY_S = 3'b010,
    BUSY_S  = 3'b100
  } ready_state_e;

  typedef struct packed {
    logic read_strobe_n;
    logic space_select_n;
    logic disk_mode_select_n;
    logic dma_ack_n;
    logic card_reset;
  } host_in_s;

  typedef struct packed {
    logic [15:0] data;
    logic        data_oe;
    logic        ready_irq;
    logic        dma_request;
  } host_out_s;

endpackage

//--- hw/card_host_strobe.sv
// Card host port: read strobe, mode select, ready/busy, interrupts, DMA handshake
module card_host_strobe
  import card_host_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire card_host_pkg::host_in_s  host_in,
  output      card_host_pkg::host_out_s host_out,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output      logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output      logic                   s_axi_wready,
  output      logic [1:0]             s_axi_bresp,
  output      logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output      logic                   s_axi_arready,
  output      logic [31:0]            s_axi_rdata,
  output      logic [1:0]             s_axi_rresp,
  output      logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output      logic                   irq
);
  import card_host_pkg::*;

  host_in_s          sync_in;
  ready_state_e      state_reg;
  logic [CNT_W-1:0]  init_cnt_reg;
  logic [CNT_W-1:0]  pulse_cnt_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [EV_W-1:0]   irq_status_reg;
  logic [EV_W-1:0]   irq_mask_reg;
  logic [15:0]       read_data_reg;
  logic [15:0]       cfg_data_reg;
  logic              disk_mode_reg;
  logic              mode_latched_reg;
  logic              dma_active_reg;
  logic              dma_request_reg;
  logic              strobe_d_reg;
  logic              ack_d_reg;
  logic              card_irq_d_reg;
  logic              reset_seen_low_reg;
  logic              card_reset_d_reg;
  logic [EV_W-1:0]   event_set;
  logic              strobe_on;
  logic              ack_edge;
  logic              reset_rise;
  logic              io_read_ok;
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic              wr_fire;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STATUS) ||
                 (a == ADDR_IRQ_MASK) || (a == ADDR_READ_DATA) || (a == ADDR_CFG_DATA);
  endfunction

  pin_sync #(
    .WIDTH       ($bits(host_in_s))
  ) u_sync (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .pin         (host_in),
    .reset_value ('1),
    .level       (sync_in)
  );

  assign strobe_on  = !sync_in.read_strobe_n;
  // Ack only counts inside an active DMA operation
  assign ack_edge   = dma_active_reg && !sync_in.dma_ack_n && ack_d_reg;
  assign reset_rise = sync_in.card_reset && !card_reset_d_reg && reset_seen_low_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_d_reg       <= 1'b0;
      ack_d_reg          <= 1'b1;
      card_irq_d_reg     <= 1'b0;
      card_reset_d_reg   <= 1'b1;
      reset_seen_low_reg <= 1'b0;
    end else begin
      strobe_d_reg     <= strobe_on;
      ack_d_reg        <= sync_in.dma_ack_n;
      card_irq_d_reg   <= ctrl_reg[CTRL_CARD_IRQ];
      card_reset_d_reg <= sync_in.card_reset;
      // A reset pin held high since power-on never reaches the card
      if (!sync_in.card_reset) begin
        reset_seen_low_reg <= 1'b1;
      end
    end
  end

  // Mode caught at end of init, once the synchronised select has settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disk_mode_reg    <= 1'b0;
      mode_latched_reg <= 1'b0;
    end else if (!mode_latched_reg && event_set[EV_INIT_DONE]) begin
      disk_mode_reg    <= !sync_in.disk_mode_select_n;
      mode_latched_reg <= 1'b1;
    end else if (reset_rise) begin
      mode_latched_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= INIT_S;
      init_cnt_reg <= '0;
    end else if (reset_rise || ctrl_reg[CTRL_SOFT_RESET]) begin
      state_reg    <= INIT_S;
      init_cnt_reg <= '0;
    end else begin
      case (state_reg)
        INIT_S: begin
          if (init_cnt_reg == CNT_W'(INIT_CYCLES - 1)) begin
            state_reg <= READY_S;
          end else begin
            init_cnt_reg <= init_cnt_reg + 1'b1;
          end
        end
        READY_S: begin
          if (ctrl_reg[CTRL_BUSY]) begin
            state_reg <= BUSY_S;
          end
        end
        BUSY_S: begin
          if (!ctrl_reg[CTRL_BUSY]) begin
            state_reg <= READY_S;
          end
        end
        default: begin
          state_reg <= INIT_S;
        end
      endcase
    end
  end

  // Pulse width counter for the pulse-style I/O interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt_reg <= '0;
    end else if (ctrl_reg[CTRL_CARD_IRQ] && !card_irq_d_reg) begin
      pulse_cnt_reg <= CNT_W'(PULSE_CYCLES);
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_active_reg  <= 1'b0;
      dma_request_reg <= 1'b0;
    end else if (!disk_mode_reg) begin
      dma_active_reg  <= 1'b0;
      dma_request_reg <= 1'b0;
    end else begin
      dma_active_reg <= ctrl_reg[CTRL_DMA_REQ] || dma_request_reg;
      if (ack_edge) begin
        dma_request_reg <= 1'b0;
      end else if (ctrl_reg[CTRL_DMA_REQ] && sync_in.dma_ack_n) begin
        dma_request_reg <= 1'b1;
      end
    end
  end

  // Card info and config space is attribute memory; I/O mode reads nothing else
  assign io_read_ok = !sync_in.space_select_n ? 1'b1 : !ctrl_reg[CTRL_IO_MODE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_out <= '{data: '0, data_oe: 1'b0, ready_irq: 1'b0, dma_request: 1'b0};
    end else begin
      host_out.data_oe <= strobe_on && io_read_ok && !disk_mode_reg;
      // Space select picks common or attribute contents
      host_out.data    <= sync_in.space_select_n ? read_data_reg : cfg_data_reg;
      host_out.dma_request <= dma_request_reg;
      if (disk_mode_reg) begin
        host_out.ready_irq <= ctrl_reg[CTRL_CARD_IRQ];
      end else if (ctrl_reg[CTRL_IO_MODE] && state_reg != INIT_S) begin
        host_out.ready_irq <= ctrl_reg[CTRL_LEVEL_IRQ] ? !ctrl_reg[CTRL_CARD_IRQ]
                                                       : (pulse_cnt_reg == '0);
      end else begin
        host_out.ready_irq <= (state_reg == READY_S);
      end
    end
  end

  assign event_set[EV_READ_STROBE] = strobe_on && !strobe_d_reg;
  assign event_set[EV_DMA_ACK]     = ack_edge;
  assign event_set[EV_INIT_DONE]   = (state_reg == INIT_S) &&
                                     (init_cnt_reg == CNT_W'(INIT_CYCLES - 1));

  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready  = !w_hold_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      aw_addr_reg  <= '0;
      w_data_reg   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                     {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_fire) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg      <= '0;
      irq_mask_reg  <= '0;
      read_data_reg <= '0;
      cfg_data_reg  <= '0;
    end else begin
      ctrl_reg[CTRL_SOFT_RESET] <= 1'b0;
      if (wr_fire) begin
        case (aw_addr_reg)
          ADDR_CTRL:      ctrl_reg      <= w_data_reg[CTRL_W-1:0];
          ADDR_IRQ_MASK:  irq_mask_reg  <= w_data_reg[EV_W-1:0];
          ADDR_READ_DATA: read_data_reg <= w_data_reg[15:0];
          ADDR_CFG_DATA:  cfg_data_reg  <= w_data_reg[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
    end else if (wr_fire && aw_addr_reg == ADDR_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~w_data_reg[EV_W-1:0]) | event_set;
    end else begin
      irq_status_reg <= irq_status_reg | event_set;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        ADDR_CTRL:       s_axi_rdata <= 32'(ctrl_reg);
        ADDR_STATUS:     s_axi_rdata <= 32'({(state_reg != INIT_S), 1'b0, dma_active_reg,
                                         disk_mode_reg, (state_reg == READY_S)});
        ADDR_IRQ_STATUS: s_axi_rdata <= 32'(irq_status_reg);
        ADDR_IRQ_MASK:   s_axi_rdata <= 32'(irq_mask_reg);
        ADDR_READ_DATA:  s_axi_rdata <= 32'(read_data_reg);
        ADDR_CFG_DATA:   s_axi_rdata <= 32'(cfg_data_reg);
        default:         s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- hw/pin_sync.sv
// Three-stage pin synchroniser; change accepted when stages two and three agree
module pin_sync
  import card_host_pkg::*;
#(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin,
  input  wire logic [WIDTH-1:0] reset_value,
  output      logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;

  always_ff @(posedge aclk) begin
    s1_reg <= pin;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // Idle levels loaded during reset, not pin values under reset
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          level_reg[i] <= reset_value[i];
        end else if (s2_reg[i] == s3_reg[i]) begin
          level_reg[i] <= s3_reg[i];
        end
      end
    end
  endgenerate

  assign level = level_reg;
endmodule

//--- testbench/card_host_props.sv
// Checker: port properties of the card host strobe block
module card_host_props
  import card_host_pkg::*;
(
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire card_host_pkg::host_in_s  host_in,
  input wire card_host_pkg::host_out_s host_out,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] since_reg;
  logic        seen_reg;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Saturates so a long run cannot wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_reg <= 16'h0000;
      seen_reg  <= 1'h0;
    end else begin
      if (since_reg != 16'hFFFF) since_reg <= since_reg + 16'h0001;
      if (host_out.ready_irq) seen_reg <= 1'h1;
    end
  end
  sequence ack_taken_q;
    host_out.dma_request && $fell(host_in.dma_ack_n);
  endsequence
  sequence ack_idle_q;
    (host_out.dma_request && host_in.dma_ack_n) [*5];
  endsequence
  AST_RESET_BUSY: assert property (disable iff (1'h0) !aresetn |=> !host_out.ready_irq)
    else $error("ready high in reset");
  AST_INIT_LOW: assert property ($rose(aresetn) |-> !host_out.ready_irq [*8])
    else $error("ready high after reset");
  AST_INIT_TIME: assert property (!seen_reg && host_out.ready_irq |-> since_reg >= 16'(INIT_CYCLES))
    else $error("ready before init done");
  AST_OE_IDLE: assert property (host_in.read_strobe_n [*8] |-> !host_out.data_oe)
    else $error("data driven without strobe");
  AST_DMA_DROP: assert property (ack_taken_q |-> ##[1:6] !host_out.dma_request)
    else $error("request kept after ack");
  AST_DMA_HOLD: assert property (ack_idle_q |=> host_out.dma_request)
    else $error("request dropped without ack");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
endmodule

bind card_host_strobe card_host_props props (
  .aclk, .aresetn, .host_in, .host_out, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rready
);

//--- testbench/host_model.sv
// Host controller model: read strobe, selects and DMA acknowledge
module host_model
  import card_host_pkg::*;
(
  input  wire logic                     aclk,
  input  wire logic                     read_go,
  input  wire logic                     space_n,
  input  wire logic                     disk_n,
  input  wire logic                     card_rst,
  input  wire logic                     ack_force,
  input  wire logic [3:0]               ack_delay,
  input  wire card_host_pkg::host_out_s host_out,
  output      card_host_pkg::host_in_s  host_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] oe_cnt = 4'h0;
  logic [3:0] ack_cnt = 4'h0;
  logic [3:0] wait_cnt = 4'h0;
  // Eight cycles low, outlasting the card's synchronisers
  always @(posedge aclk) begin
    if (read_go) oe_cnt <= 4'h8;
    else if (oe_cnt != 4'h0) oe_cnt <= oe_cnt - 4'h1;
  end
  always @(posedge aclk) begin
    if (ack_cnt != 4'h0) ack_cnt <= ack_cnt - 4'h1;
    else if (host_out.dma_request !== 1'h1) wait_cnt <= 4'h0;
    else if (wait_cnt == ack_delay) begin
      ack_cnt  <= 4'h6;
      wait_cnt <= 4'h0;
    end else wait_cnt <= wait_cnt + 4'h1;
  end
  // Chip selects not modelled; ack idles high
  assign host_in = {oe_cnt == 4'h0, space_n, disk_n, ack_cnt == 4'h0 && !ack_force, card_rst};
endmodule

//--- testbench/tb_top.sv
// Testbench top: AXI-Lite master, host model and scenarios
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import card_host_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_s;
  logic        aclk = 1'h0, aresetn = 1'h0, read_go = 1'h0, space_n = 1'h1, disk_n = 1'h1;
  logic        card_rst = 1'h1, ack_force = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, prev = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb = 4'hF, ack_delay = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  host_in_s    host_in;
  host_out_s   host_out;
  int          mismatches = 0, comparisons = 0, cycles = 0, lows = 0, rises = 0;
  bit          count_on = 0;
  row_s        rows [10] = '{
    '{1'h0, 8'h00, 32'h0, 2'h0}, '{1'h0, 8'h04, 32'h11, 2'h0}, '{1'h0, 8'h08, 32'h4, 2'h0},
    '{1'h1, 8'h0C, 32'h0, 2'h0}, '{1'h1, 8'h08, 32'h4, 2'h0}, '{1'h0, 8'h08, 32'h0, 2'h0},
    '{1'h0, 8'h18, 32'h0, 2'h2}, '{1'h1, 8'h1C, 32'h0, 2'h2}, '{1'h1, 8'h00, 32'h1, 2'h0},
    '{1'h0, 8'h00, 32'h1, 2'h0}};
  card_host_strobe dut (
    .aclk, .aresetn, .host_in, .host_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  host_model model (
    .aclk, .read_go, .space_n, .disk_n, .card_rst, .ack_force, .ack_delay, .host_out,
    .host_in);
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      end_of_test();
    end
  end
  always @(negedge aclk) begin
    if (count_on && host_out.ready_irq === 1'h0) lows++;
    if (host_out.dma_request === 1'h1 && !prev) rises++;
    prev = host_out.dma_request === 1'h1;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Ready raised late so the slave must hold its answer
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, fin;
    fin = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    for (int n = 0; !fin; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      fin = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tr) s_axi_arvalid <= 1'h0;
      if (fin) begin
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
      end else if (n == 2) begin
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
      end
    end
    @(negedge aclk);
  endtask
  task automatic strobe(input logic sp, input logic oe, input logic [15:0] ed);
    @(posedge aclk);
    space_n <= sp;
    read_go <= 1'h1;
    @(posedge aclk);
    read_go <= 1'h0;
    repeat (6) @(negedge aclk);
    chk("data_oe", 32'(oe), 32'(host_out.data_oe));
    if (oe) chk("data", 32'(ed), 32'(host_out.data));
    repeat (12) @(negedge aclk);
  endtask
  task automatic wait_for(input logic v);
    for (int n = 0; n < 1200 && host_out.ready_irq !== v; n++) @(negedge aclk);
    chk("ready_irq", 32'(v), 32'(host_out.ready_irq));
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (900) @(negedge aclk);
    chk("ready_early", 32'h0, 32'(host_out.ready_irq));
    wait_for(1'h1);
    for (int i = 0; i < 10; i++) begin
      axi(rows[i].wr, rows[i].a, rows[i].d);
      chk("resp", 32'(rows[i].r), 32'(r));
      if (!rows[i].wr) chk("rdata", rows[i].d, q);
    end
    wait_for(1'h0);
    axi(1'h1, ADDR_CTRL, 32'h0);
    wait_for(1'h1);
    axi(1'h1, ADDR_READ_DATA, 32'h1234);
    axi(1'h1, ADDR_CFG_DATA, 32'hABCD);
    strobe(1'h1, 1'h1, 16'h1234);
    chk("irq_masked", 32'h0, 32'(irq));
    axi(1'h1, ADDR_IRQ_MASK, 32'h1);
    chk("irq_set", 32'h1, 32'(irq));
    axi(1'h1, ADDR_IRQ_STATUS, 32'h1);
    chk("irq_clear", 32'h0, 32'(irq));
    strobe(1'h0, 1'h1, 16'hABCD);
    chk("irq_again", 32'h1, 32'(irq));
    axi(1'h1, ADDR_CTRL, 32'h2);
    wait_for(1'h1);
    strobe(1'h1, 1'h0, 16'h0);
    strobe(1'h0, 1'h1, 16'hABCD);
    count_on = 1'h1;
    axi(1'h1, ADDR_CTRL, 32'hA);
    repeat (40) @(negedge aclk);
    chk("pulse_len", PULSE_CYCLES, 32'(lows));
    axi(1'h1, ADDR_CTRL, 32'hE);
    repeat (30) @(negedge aclk);
    chk("level_irq", 32'h0, 32'(host_out.ready_irq));
    axi(1'h1, ADDR_CTRL, 32'h6);
    wait_for(1'h1);
    @(posedge aclk);
    disk_n <= 1'h0;
    aresetn <= 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (INIT_CYCLES + 20) @(negedge aclk);
    axi(1'h0, ADDR_STATUS, 32'h0);
    chk("disk_mode", 32'h12, q & 32'h12);
    chk("disk_interrupt_request_idle", 32'h0, 32'(host_out.ready_irq));
    strobe(1'h1, 1'h0, 16'h0);
    @(posedge aclk);
    ack_force <= 1'h1;
    repeat (6) @(posedge aclk);
    ack_force <= 1'h0;
    axi(1'h0, ADDR_IRQ_STATUS, 32'h0);
    chk("stray_ack", 32'h0, q & 32'h2);
    chk("no_dma", 32'h0, 32'(host_out.dma_request));
    axi(1'h1, ADDR_CTRL, 32'h8);
    wait_for(1'h1);
    axi(1'h1, ADDR_CTRL, 32'h0);
    wait_for(1'h0);
    axi(1'h1, ADDR_CTRL, 32'h10);
    repeat (150) @(posedge aclk);
    ack_delay <= 4'h9;
    repeat (150) @(negedge aclk);
    chk("dma_rounds", 32'h1, 32'(rises > 3));
    end_of_test();
  end
endmodule
